/* inc/sweep_pkg.sv */
/*
 * Constants and types for the sweep control and frequency word block.
 * Assumes a complete 16-bit serial word is presented by framing logic on core_clk.
 */
package sweep_pkg;

	localparam logic [3:0]  ADDR_CONTROL    = 4'h0;
	localparam logic [3:0]  ADDR_STEP_COUNT = 4'h1;
	localparam logic [3:0]  ADDR_STEP_LOW   = 4'h2;
	localparam logic [3:0]  ADDR_STEP_HIGH  = 4'h3;
	localparam logic [3:0]  ADDR_START_LOW  = 4'hc;
	localparam logic [3:0]  ADDR_START_HIGH = 4'hd;

	localparam int          HALF_W          = 12;
	localparam int          START_W         = 24;
	localparam int          STEP_W          = 23;
	localparam int          STEP_DIR_BIT    = 11;
	localparam logic [11:0] CONTROL_RESET   = 12'h003;
	localparam logic [2:0]  MARKER_PULSE_CYCLES = 3'h4;

	// Control bits in word order, bit 11 down to bit 0.
	typedef struct packed {
		logic       paired_write_select;
		logic       dac_enable;
		logic       sine_select;
		logic       msb_output_enable;
		logic       continuous_or_pulsed_select;
		logic       burst_source_select;
		logic       step_source_select;
		logic       sawtooth_select;
		logic       marker_select;
		logic       marker_output_enable;
		logic [1:0] reserved_ones;
	} ctrl_t;

	typedef struct packed {
		logic [3:0]  addr;
		logic [11:0] data;
	} word_t;

	typedef enum logic [1:0] {
		SW_IDLE,
		SW_RUN,
		SW_DONE
	} sweep_state_t;

endpackage

/* core/sweep_control_and_frequency_words.sv */
/*
 * Control bit decode, start and step frequency words, and the sweep sequencer
 * that steps the frequency, gates bursts to midscale and drives the marker pin.
 * Assumes word_valid pulses once per complete serial word on core_clk, and that
 * the step count, interval and burst length come from registers held elsewhere.
 */
`timescale 1ns/10ps

module sweep_control_and_frequency_words #(
	parameter int COUNT_W    = 12,
	parameter int INTERVAL_W = 11
) (
	input  wire logic                     core_clk,
	input  wire logic                     reset,
	input  wire logic                     word_valid,
	input  wire sweep_pkg::word_t         word,
	input  wire logic                     trigger_pin,
	input  wire logic [COUNT_W-1:0]       step_count,
	input  wire logic [INTERVAL_W-1:0]    increment_interval,
	input  wire logic [INTERVAL_W-1:0]    burst_length,
	input  wire logic                     count_output_cycles,
	input  wire logic                     output_cycle_tick,
	output sweep_pkg::ctrl_t              control_q,
	output logic [sweep_pkg::START_W-1:0] start_frequency_word_q,
	output logic [sweep_pkg::STEP_W-1:0]  freq_step_q,
	output logic                          step_down_q,
	output logic [sweep_pkg::START_W-1:0] current_freq_q,
	output logic                          midscale_q,
	output logic                          sweep_running_q,
	output logic                          sweep_finished_q,
	output logic                          marker_pin_q,
	output logic                          marker_pin_oe_n_q
);
	import sweep_pkg::*;

	// ------------------------------------------------------------
	// Trigger pin synchroniser and edge detect.
	// ------------------------------------------------------------
	logic trigger_meta_q;
	logic trigger_sync_q;
	logic trigger_prev_q;
	logic trigger_rise;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			trigger_meta_q <= 1'b0;
			trigger_sync_q <= 1'b0;
			trigger_prev_q <= 1'b0;
		end else begin
			trigger_meta_q <= trigger_pin;
			trigger_sync_q <= trigger_meta_q;
			trigger_prev_q <= trigger_sync_q;
		end
	end

	assign trigger_rise = trigger_sync_q & ~trigger_prev_q;

	// ------------------------------------------------------------
	// Word decode.
	// ------------------------------------------------------------
	logic wr_control;
	logic wr_start_low;
	logic wr_start_high;
	logic wr_step_low;
	logic wr_step_high;

	// Reserved and foreign codes match nothing here and change no state.
	assign wr_control    = word_valid && (word.addr == ADDR_CONTROL);
	assign wr_start_low  = word_valid && (word.addr == ADDR_START_LOW);
	assign wr_start_high = word_valid && (word.addr == ADDR_START_HIGH);
	assign wr_step_low   = word_valid && (word.addr == ADDR_STEP_LOW);
	assign wr_step_high  = word_valid && (word.addr == ADDR_STEP_HIGH);

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			control_q <= ctrl_t'(CONTROL_RESET);
		end else if (wr_control) begin
			control_q <= ctrl_t'(word.data);
		end
	end

	// ------------------------------------------------------------
	// Start frequency word.
	// ------------------------------------------------------------
	logic [HALF_W-1:0] start_hold_q;
	logic              start_pending_q;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			start_frequency_word_q <= '0;
			start_hold_q           <= '0;
			start_pending_q        <= 1'b0;
		end else if (control_q.paired_write_select) begin
			if (wr_start_low) begin
				start_hold_q    <= word.data;
				start_pending_q <= 1'b1;
			end else if (wr_start_high && start_pending_q) begin
				start_frequency_word_q <= {word.data, start_hold_q};
				start_pending_q        <= 1'b0;
			end
		end else begin
			start_pending_q <= 1'b0;
			if (wr_start_low) begin
				start_frequency_word_q[HALF_W-1:0] <= word.data;
			end
			if (wr_start_high) begin
				start_frequency_word_q[START_W-1:HALF_W] <= word.data;
			end
		end
	end

	// ------------------------------------------------------------
	// Frequency step word and direction.
	// ------------------------------------------------------------
	logic [HALF_W-1:0] step_hold_q;
	logic              step_pending_q;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			freq_step_q    <= '0;
			step_down_q    <= 1'b0;
			step_hold_q    <= '0;
			step_pending_q <= 1'b0;
		end else if (control_q.paired_write_select) begin
			if (wr_step_low) begin
				step_hold_q    <= word.data;
				step_pending_q <= 1'b1;
			end else if (wr_step_high && step_pending_q) begin
				freq_step_q    <= {word.data[STEP_W-HALF_W-1:0], step_hold_q};
				step_down_q    <= word.data[STEP_DIR_BIT];
				step_pending_q <= 1'b0;
			end
		end else begin
			step_pending_q <= 1'b0;
			if (wr_step_low) begin
				freq_step_q[HALF_W-1:0] <= word.data;
			end
			if (wr_step_high) begin
				freq_step_q[STEP_W-1:HALF_W] <= word.data[STEP_W-HALF_W-1:0];
				step_down_q                  <= word.data[STEP_DIR_BIT];
			end
		end
	end

	// ------------------------------------------------------------
	// Sweep timing.
	// ------------------------------------------------------------
	sweep_state_t         state_q;
	sweep_state_t         state_d;
	logic [COUNT_W-1:0]    inc_cnt_q;
	logic [INTERVAL_W-1:0] interval_cnt_q;
	logic [INTERVAL_W-1:0] burst_cnt_q;
	logic                  falling_q;
	logic                  unit_tick;
	logic                  interval_end;
	logic                  step_event;
	logic                  start_event;
	logic                  last_step;
	logic                  end_event;
	logic                  external_burst;
	logic                  subtract;
	logic [START_W-1:0]    step_ext;

	assign unit_tick    = count_output_cycles ? output_cycle_tick : 1'b1;
	assign interval_end = unit_tick && (interval_cnt_q + 1'b1 >= increment_interval);
	// External stepping takes the window from the trigger rising edges.
	assign step_event   = (state_q == SW_RUN)
		&& (control_q.step_source_select ? trigger_rise : interval_end);
	assign start_event  = (state_q != SW_RUN) && trigger_rise;
	assign last_step    = (inc_cnt_q == step_count);
	assign end_event    = step_event && last_step && (control_q.sawtooth_select || falling_q);
	// The burst source only counts when steps come from the trigger pin.
	assign external_burst = control_q.step_source_select && control_q.burst_source_select;
	assign subtract     = step_down_q ^ falling_q;
	assign step_ext     = {1'b0, freq_step_q};

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			SW_IDLE: begin
				if (start_event) begin
					state_d = SW_RUN;
				end
			end
			SW_RUN: begin
				if (end_event) begin
					state_d = SW_DONE;
				end
			end
			SW_DONE: begin
				if (start_event) begin
					state_d = SW_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_q <= SW_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			interval_cnt_q <= '0;
			burst_cnt_q    <= '0;
		end else if (start_event || step_event) begin
			interval_cnt_q <= '0;
			burst_cnt_q    <= '0;
		end else if (unit_tick) begin
			interval_cnt_q <= interval_cnt_q + 1'b1;
			if (burst_cnt_q != {INTERVAL_W{1'b1}}) begin
				burst_cnt_q <= burst_cnt_q + 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Frequency stepping.
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			current_freq_q <= '0;
			inc_cnt_q      <= '0;
			falling_q      <= 1'b0;
		end else if (start_event) begin
			current_freq_q <= start_frequency_word_q;
			inc_cnt_q      <= '0;
			falling_q      <= 1'b0;
		end else if (step_event && !end_event) begin
			if (last_step) begin
				// Triangular profile turns round and walks back towards the start frequency.
				falling_q      <= 1'b1;
				inc_cnt_q      <= COUNT_W'(1);
				current_freq_q <= subtract ? current_freq_q + step_ext : current_freq_q - step_ext;
			end else begin
				inc_cnt_q      <= inc_cnt_q + 1'b1;
				current_freq_q <= subtract ? current_freq_q - step_ext : current_freq_q + step_ext;
			end
		end
	end

	// ------------------------------------------------------------
	// Burst gating and run flags.
	// ------------------------------------------------------------
	logic midscale_d;

	always_comb begin
		midscale_d = 1'b0;
		if (state_d == SW_RUN && !control_q.continuous_or_pulsed_select) begin
			if (external_burst) begin
				midscale_d = ~trigger_sync_q;
			end else begin
				midscale_d = (burst_cnt_q >= burst_length) && !(start_event || step_event);
			end
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			midscale_q       <= 1'b0;
			sweep_running_q  <= 1'b0;
			sweep_finished_q <= 1'b0;
		end else begin
			midscale_q       <= midscale_d;
			sweep_running_q  <= (state_d == SW_RUN);
			sweep_finished_q <= (state_d == SW_DONE);
		end
	end

	// ------------------------------------------------------------
	// Marker pin.
	// ------------------------------------------------------------
	logic [2:0] pulse_cnt_q;
	logic [2:0] pulse_cnt_d;
	logic       increment_seen;

	assign increment_seen = step_event && !end_event;

	always_comb begin
		pulse_cnt_d = pulse_cnt_q;
		if (increment_seen) begin
			pulse_cnt_d = MARKER_PULSE_CYCLES;
		end else if (pulse_cnt_q != 3'h0) begin
			pulse_cnt_d = pulse_cnt_q - 3'h1;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pulse_cnt_q       <= 3'h0;
			marker_pin_q      <= 1'b0;
			marker_pin_oe_n_q <= 1'b1;
		end else begin
			pulse_cnt_q       <= pulse_cnt_d;
			if (control_q.marker_select) begin
				marker_pin_q <= (state_d == SW_DONE);
			end else begin
				marker_pin_q <= (pulse_cnt_d != 3'h0);
			end
			marker_pin_oe_n_q <= ~control_q.marker_output_enable;
		end
	end

endmodule

/* tb/sweep_host_model.sv */
/* Host model that sends complete 16-bit words to the sweep control block.
   Assumes a word is taken at a rising core_clk edge while word_valid is high. */
`timescale 1ns/10ps
module sweep_host_model (
	input  wire logic        core_clk,
	output logic             word_valid,
	output sweep_pkg::word_t word
);
	import sweep_pkg::*;
	initial begin
		word_valid = 1'b0;
		word       = '0;
	end
	task automatic send(input logic [3:0] a, input logic [11:0] d);
		logic [11:0] v;
		v = d;
		if (a == ADDR_CONTROL) begin
			v[1:0] = 2'b11;
		end
		@(posedge core_clk);
		word_valid <= 1'b1;
		word       <= {a, v};
		@(posedge core_clk);
		word_valid <= 1'b0;
		word       <= ~{a, v};
	endtask
endmodule

/* tb/sweep_monitor.sv */
/* Checker for the sweep control block, bound to its ports.
   Assumes one clock domain with an asynchronous active-high reset. */
`timescale 1ns/10ps
module sweep_monitor (
	input wire logic              core_clk,
	input wire logic              reset,
	input wire logic              word_valid,
	input wire sweep_pkg::word_t  word,
	input wire sweep_pkg::ctrl_t  control_q,
	input wire logic [23:0]       start_frequency_word_q,
	input wire logic [22:0]       freq_step_q,
	input wire logic              step_down_q,
	input wire logic [23:0]       current_freq_q,
	input wire logic              midscale_q,
	input wire logic              sweep_running_q,
	input wire logic              sweep_finished_q,
	input wire logic              marker_pin_q,
	input wire logic              marker_pin_oe_n_q
);
	import sweep_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	sequence s_ctrl_settled;
		$stable(control_q) ##1 $stable(control_q);
	endsequence
	sequence s_pulse_hold;
		marker_pin_q [*4] ##1 !marker_pin_q;
	endsequence
	property p_ctrl_write;
		word_valid && word.addr == ADDR_CONTROL |=> control_q == $past(word.data);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control bits not taken");
	property p_start_half;
		word_valid && word.addr == ADDR_START_LOW && !control_q.paired_write_select
		|=> start_frequency_word_q == {$past(start_frequency_word_q[23:12]), $past(word.data)};
	endproperty
	a_start_half: assert property (p_start_half) else $error("start low half wrong");
	property p_paired_hold;
		word_valid && word.addr == ADDR_START_LOW && control_q.paired_write_select |=> $stable(start_frequency_word_q);
	endproperty
	a_paired_hold: assert property (p_paired_hold) else $error("paired low half applied early");
	property p_reserved;
		word_valid && word.addr inside {[4'h4:4'hb], 4'he, 4'hf}
		|=> $stable(control_q) && $stable(start_frequency_word_q) && $stable(freq_step_q) && $stable(step_down_q);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved code changed state");
	property p_step_high;
		word_valid && word.addr == ADDR_STEP_HIGH && !control_q.paired_write_select
		|=> freq_step_q[22:12] == $past(word.data[10:0]) && step_down_q == $past(word.data[11]);
	endproperty
	a_step_high: assert property (p_step_high) else $error("step high word wrong");
	property p_oe;
		s_ctrl_settled |-> marker_pin_oe_n_q == !control_q.marker_output_enable;
	endproperty
	a_oe: assert property (p_oe) else $error("marker enable mismatch");
	property p_cont;
		s_ctrl_settled ##0 control_q.continuous_or_pulsed_select |-> !midscale_q;
	endproperty
	a_cont: assert property (p_cont) else $error("midscale in continuous mode");
	property p_pulse;
		$rose(marker_pin_q) && !control_q.marker_select && control_q.marker_output_enable |-> s_pulse_hold;
	endproperty
	a_pulse: assert property (p_pulse) else $error("marker pulse length wrong");
	property p_eos;
		control_q.marker_select && control_q.marker_output_enable && sweep_finished_q
		&& $past(sweep_finished_q) && $stable(control_q) |-> marker_pin_q;
	endproperty
	a_eos: assert property (p_eos) else $error("marker low at sweep end");
	property p_first;
		$rose(sweep_running_q) |-> current_freq_q == start_frequency_word_q;
	endproperty
	a_first: assert property (p_first) else $error("sweep did not open at start");
	property p_step;
		sweep_running_q && $past(sweep_running_q) && $changed(current_freq_q) && control_q.sawtooth_select
		|-> current_freq_q == (step_down_q ? $past(current_freq_q) - {1'b0, freq_step_q}
		: $past(current_freq_q) + {1'b0, freq_step_q});
	endproperty
	a_step: assert property (p_step) else $error("increment size wrong");
endmodule
bind sweep_control_and_frequency_words sweep_monitor i_sweep_monitor (.core_clk, .reset, .word_valid, .word,
	.control_q, .start_frequency_word_q, .freq_step_q, .step_down_q, .current_freq_q, .midscale_q,
	.sweep_running_q, .sweep_finished_q, .marker_pin_q, .marker_pin_oe_n_q);

/* tb/sweep_control_and_frequency_words_tb.sv */
/* Self-checking bench for the sweep control block.
   Assumes the host model and the bound checker are compiled alongside. */
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_total++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module sweep_control_and_frequency_words_tb;
	import sweep_pkg::*;
	logic        core_clk = 1'b0, reset = 1'b1, trigger_pin = 1'b0, word_valid, seen, gap;
	word_t       word;
	ctrl_t       control_q;
	logic [23:0] start_frequency_word_q, current_freq_q;
	logic [22:0] freq_step_q;
	logic        step_down_q, midscale_q, sweep_running_q, sweep_finished_q, marker_pin_q, marker_pin_oe_n_q;
	int          err_total = 0, checks = 0;
	always #20 core_clk = ~core_clk;
	sweep_host_model i_sweep_host_model (.core_clk, .word_valid, .word);
	sweep_control_and_frequency_words i_sweep_control_and_frequency_words (.core_clk, .reset, .word_valid,
		.word, .trigger_pin, .step_count(12'h002), .increment_interval(11'h008), .burst_length(11'h001),
		.count_output_cycles(1'b0), .output_cycle_tick(1'b0), .control_q, .start_frequency_word_q,
		.freq_step_q, .step_down_q, .current_freq_q, .midscale_q, .sweep_running_q, .sweep_finished_q,
		.marker_pin_q, .marker_pin_oe_n_q);
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic finish_test;
		$display("checks=%0d err_total=%0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [11:0] d);
		i_sweep_host_model.send(a, d);
		#1;
	endtask
	task automatic trig;
		@(posedge core_clk) trigger_pin <= 1'b1;
		repeat (3) @(posedge core_clk);
		trigger_pin <= 1'b0;
		repeat (3) @(posedge core_clk);
		#1;
	endtask
	task automatic run_sweep(input logic [11:0] c, input logic [23:0] fin_f, input int cyc);
		int n;
		wr(ADDR_CONTROL, c);
		seen = 1'b0;
		gap  = 1'b0;
		trig();
		for (n = 0; n < 300 && sweep_finished_q !== 1'b1; n++) begin
			@(posedge core_clk);
			#1;
			seen = seen | midscale_q;
			gap  = gap | (sweep_running_q && !midscale_q);
		end
		if (n == 300) begin
			err_total++;
			finish_test();
		end
		`CHK(n, cyc)
		repeat (2) @(posedge core_clk);
		#1;
		`CHK(current_freq_q, fin_f)
		`CHK(seen, !c[7])
		`CHK(gap, 1'b1)
		`CHK(marker_pin_oe_n_q, !c[2])
		`CHK(marker_pin_q, c[3])
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		#1;
		`CHK(control_q, CONTROL_RESET)
		wr(ADDR_START_LOW, 12'h123);
		wr(ADDR_START_HIGH, 12'h456);
		`CHK(start_frequency_word_q, 24'h456123)
		wr(ADDR_START_LOW, 12'h789);
		`CHK(start_frequency_word_q, 24'h456789)
		for (int a = 4; a < 16; a++) begin
			if (a < 12 || a > 13) begin
				wr(4'(a), 12'hfff);
			end
		end
		`CHK({control_q, start_frequency_word_q}, {CONTROL_RESET, 24'h456789})
		wr(ADDR_CONTROL, 12'h803);
		wr(ADDR_START_LOW, 12'h100);
		`CHK(start_frequency_word_q, 24'h456789)
		wr(ADDR_START_HIGH, 12'h000);
		`CHK(start_frequency_word_q, 24'h000100)
		wr(ADDR_CONTROL, 12'h003);
		wr(ADDR_STEP_LOW, 12'h345);
		wr(ADDR_STEP_HIGH, 12'h812);
		`CHK({step_down_q, freq_step_q}, 24'h812345)
		wr(ADDR_CONTROL, 12'h803);
		wr(ADDR_STEP_LOW, 12'h010);
		`CHK({step_down_q, freq_step_q}, 24'h812345)
		wr(ADDR_STEP_HIGH, 12'h000);
		`CHK({step_down_q, freq_step_q}, 24'h000010)
		run_sweep(12'h097, 24'h000120, 21);
		run_sweep(12'h087, 24'h000100, 37);
		run_sweep(12'h057, 24'h000120, 21);
		run_sweep(12'h01f, 24'h000120, 21);
		wr(ADDR_STEP_HIGH, 12'h800);
		run_sweep(12'h097, 24'h0000e0, 21);
		wr(ADDR_STEP_HIGH, 12'h000);
		wr(ADDR_CONTROL, 12'h0b7);
		trig();
		repeat (10) @(posedge core_clk);
		#1;
		`CHK(current_freq_q, 24'h000100)
		trig();
		`CHK(current_freq_q, 24'h000110)
		wr(ADDR_CONTROL, 12'h077);
		repeat (2) @(posedge core_clk);
		#1;
		`CHK(midscale_q, 1'b1)
		@(posedge core_clk) trigger_pin <= 1'b1;
		repeat (4) @(posedge core_clk);
		#1;
		`CHK(midscale_q, 1'b0)
		`CHK(current_freq_q, 24'h000120)
		@(posedge core_clk) trigger_pin <= 1'b0;
		finish_test();
	end
endmodule
